// ==== include/region_decode_defs.vh ====
// Register offsets, field positions and reset values of the region decoder
`ifndef REGION_DECODE_DEFS_VH
`define REGION_DECODE_DEFS_VH

`define REGION0_OFFSET      32'hffffe400
`define REGION1_OFFSET      32'hffffe404
`define REGION2_OFFSET      32'hffffe408
`define REGION3_OFFSET      32'hffffe40c
`define REGION_OFFSET_MASK  32'hfffffff0
`define REGION_INDEX_LSB    2
`define REGION_INDEX_MSB    3
`define START_HIGH_LSB      16
`define START_HIGH_MSB      31
`define MASK_LSB            0
`define MASK_MSB            15
`define LOW_MASK_TOP_BIT    29
`define HIGH_MASK_TOP_BIT   30
`define REGION_RESET        32'h000003ff
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// ==== hdl/region_match.v ====
// One region comparator: base and mask against a bus address
`timescale 1ns/100ps
`include "region_decode_defs.vh"
module region_match #(
    parameter TOP_BIT = 29
) (
    input  wire [31:0] addr,
    input  wire [31:0] base_mask,
    output wire        hit
);
    wire [31:0] start_addr;
    wire [31:0] care;
    genvar i;

    // Low 16 start bits are zero: 64 KB steps
    assign start_addr = {base_mask[`START_HIGH_MSB:`START_HIGH_LSB], 16'h0000};

    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_care
            if (i > TOP_BIT)
            begin : g_above
                assign care[i] = 1'b1;
            end
            else if (i >= TOP_BIT - `MASK_MSB)
            begin : g_range
                assign care[i] = ~base_mask[i - (TOP_BIT - `MASK_MSB)];
            end
            else
            begin : g_below
                assign care[i] = 1'b0;
            end
        end
    endgenerate

    assign hit = ((addr ^ start_addr) & care) == 32'h00000000;
endmodule // region_match

// ==== hdl/region_decoder.v ====
// Four-region chip-select decoder with AXI4-Lite register slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "region_decode_defs.vh"
module region_decoder (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [31:0] bus_addr,
    input  wire        bus_cycle,
    output reg  [3:0]  region_select
);
    reg  [31:0] region_reg [0:3];
    reg  [31:0] awaddr_reg;
    reg         aw_held_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    reg         w_held_reg;
    wire [3:0]  hit;
    integer     k;

    function is_mapped;
        input [31:0] a;
        begin
            is_mapped = (a & `REGION_OFFSET_MASK) == `REGION0_OFFSET;
        end
    endfunction

    // Byte offsets inside a word alias to it; only the word index is decoded
    function [1:0] reg_index;
        input [31:0] a;
        begin
            reg_index = a[`REGION_INDEX_MSB:`REGION_INDEX_LSB];
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    merge[b*8 +: 8] = data[b*8 +: 8];
        end
    endfunction

    // Write channel: address and data accepted in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= 32'h00000000;
            wdata_reg     <= 32'h00000000;
            wstrb_reg     <= 4'h0;
            for (k = 0; k < 4; k = k + 1)
                region_reg[k] <= `REGION_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_reg    <= s_axi_awaddr;
                aw_held_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                w_held_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_held_reg && w_held_reg && !s_axi_bvalid)
            begin
                if (is_mapped(awaddr_reg))
                begin
                    region_reg[reg_index(awaddr_reg)] <=
                        merge(region_reg[reg_index(awaddr_reg)], wdata_reg, wstrb_reg);
                    s_axi_bresp <= `AXI_RESP_OKAY;
                end
                else
                    s_axi_bresp <= `AXI_RESP_SLVERR;
                s_axi_bvalid <= 1'b1;
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: one cycle to answer
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (is_mapped(s_axi_araddr))
            begin
                s_axi_rdata <= region_reg[reg_index(s_axi_araddr)];
                s_axi_rresp <= `AXI_RESP_OKAY;
            end
            else
            begin
                // Unmapped reads return zero so no stale word leaks to software
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `AXI_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // regions 0 and 1 mask A29..A14
    region_match #(.TOP_BIT(`LOW_MASK_TOP_BIT)) u_match0 (
        .addr      (bus_addr),
        .base_mask (region_reg[0]),
        .hit       (hit[0])
    );
    region_match #(.TOP_BIT(`LOW_MASK_TOP_BIT)) u_match1 (
        .addr      (bus_addr),
        .base_mask (region_reg[1]),
        .hit       (hit[1])
    );
    // regions 2 and 3 mask A30..A15
    region_match #(.TOP_BIT(`HIGH_MASK_TOP_BIT)) u_match2 (
        .addr      (bus_addr),
        .base_mask (region_reg[2]),
        .hit       (hit[2])
    );
    region_match #(.TOP_BIT(`HIGH_MASK_TOP_BIT)) u_match3 (
        .addr      (bus_addr),
        .base_mask (region_reg[3]),
        .hit       (hit[3])
    );

    // Registered selects trade one cycle of latency for clean outputs
    // Overlapping regions all assert; there is no priority between them
    always @(posedge aclk)
    begin
        if (!aresetn)
            region_select <= 4'h0;
        else
            region_select <= bus_cycle ? hit : 4'h0;
    end
endmodule // region_decoder

// ==== testbench/region_decoder_monitor.sv ====
// Port assertions for the region decoder
`timescale 1ns/100ps
module region_decoder_monitor (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        bus_cycle,
    input wire [3:0]  region_select
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_idle; !bus_cycle |=> region_select == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("select without cycle");
    property p_cause; region_select != 4'h0 |-> $past(bus_cycle); endproperty
    a_cause: assert property (p_cause) else $error("select with no cause");
    property p_awtake; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_awtake: assert property (p_awtake) else $error("awready stayed");
    property p_artake; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_artake: assert property (p_artake) else $error("late read answer");
    property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid; endproperty
    a_wresp: assert property (p_wresp) else $error("late write answer");
    property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
    endproperty
    a_bdone: assert property (p_bdone) else $error("write not closed");
    property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_rdone: assert property (p_rdone) else $error("read not closed");
    property p_unmap; s_axi_arvalid && s_axi_arready && s_axi_araddr[31:4] != 28'hffffe40
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_hit: cover property (bus_cycle ##1 region_select[3]);
endmodule // region_decoder_monitor
bind region_decoder region_decoder_monitor region_decoder_monitor_i (.*);

// ==== testbench/ext_devices.sv ====
// Devices behind the four selects; each remembers being accessed
`timescale 1ns/100ps
module ext_devices (
    input wire       aclk,
    input wire       aresetn,
    input wire [3:0] region_select,
    output reg [3:0] touched_reg
);
    // each device answers to its select
    always @(posedge aclk)
    begin
        if (!aresetn)
            touched_reg <= 4'h0;
        else
            touched_reg <= touched_reg | region_select;
    end
endmodule // ext_devices

// ==== testbench/testbench.sv ====
// Register and decode tests for the region decoder
`timescale 1ns/100ps
`include "region_decode_defs.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module testbench;
    logic        aclk = 0, aresetn = 0, bus_cycle = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, bus_addr = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [3:0]  region_select, touched;
    int          mismatches = 0, samples_checked = 0;
    region_decoder region_decoder_i (.*);
    ext_devices ext_devices_i (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .region_select (region_select),
        .touched_reg   (touched)
    );
    initial forever #5 aclk = ~aclk;
    task automatic wr(input [31:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", r, s_axi_bresp)
    endtask
    task automatic rd(input [31:0] a, input [31:0] d, input [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK("rdata", d, s_axi_rdata)
        `CHK("rresp", r, s_axi_rresp)
    endtask
    task automatic probe(input [31:0] a, input c, input [3:0] e);
        @(posedge aclk);
        bus_addr <= a;
        bus_cycle <= c;
        @(posedge aclk);
        #1 `CHK("region_select", e, region_select)
    endtask
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        end_of_test;
    end
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++)
            rd(`REGION0_OFFSET + 4 * i, `REGION_RESET, 2'h0);
        rd(32'hffffe410, 32'h0, 2'h2);
        wr(32'hffffe410, 32'h1, 4'hf, 2'h2);
        wr(`REGION0_OFFSET, 32'hc0000000, 4'hf, 2'h0);
        wr(`REGION1_OFFSET, 32'h00800200, 4'hf, 2'h0);
        wr(`REGION2_OFFSET, 32'h1fd0001f, 4'hf, 2'h0);
        wr(`REGION3_OFFSET, 32'h12340000, 4'hf, 2'h0);
        wr(`REGION3_OFFSET, 32'hffff5678, 4'hc, 2'h0);
        rd(`REGION2_OFFSET, 32'h1fd0001f, 2'h0);
        rd(`REGION3_OFFSET, 32'hffff0000, 2'h0);
        $display("register test done");
        probe(32'hc0001234, 1'b1, 4'h1);
        probe(32'hc0004000, 1'b1, 4'h0);
        probe(32'h00003fff, 1'b1, 4'h2);
        probe(32'h01003fff, 1'b1, 4'h0);
        probe(32'h40000000, 1'b1, 4'h0);
        probe(32'h1fdfffff, 1'b1, 4'h4);
        probe(32'h1fe00000, 1'b1, 4'h0);
        probe(32'hffff4000, 1'b1, 4'h8);
        probe(32'hffff8000, 1'b1, 4'h0);
        probe(32'hc0001234, 1'b0, 4'h0);
        `CHK("touched", 4'hf, touched)
        $display("decode test done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`REGION3_OFFSET, `REGION_RESET, 2'h0);
        probe(32'h00003fff, 1'b1, 4'hf);
        $display("reset test done");
        end_of_test;
    end
endmodule // testbench
